// >>> scs_phase_if.sv
`timescale 1ns/1ps
`default_nettype none

interface scs_phase_if;
  logic start;
  logic sel_high;
  logic [7:0] divider;
  logic done;

  modport ctrl (output start, output sel_high, output divider, input done);
  modport timer (input start, input sel_high, input divider, output done);
endinterface

`default_nettype wire

// >>> scs_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none

module scs_phase_timer
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Phase request and completion
  scs_phase_if.timer ph
);

  scs_len_t cnt_q, cnt_d;
  logic run_q, run_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (ph.start) begin
      run_d = 1'b1;
      // Phase length from the divider
      cnt_d = (ph.sel_high ? scs_high_len(ph.divider) : scs_low_len(ph.divider)) - 8'h01;
    end else if (run_q && (cnt_q == 8'h00)) begin
      run_d = 1'b0;
    end else if (run_q) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign ph.done = run_q && (cnt_q == 8'h00);

  a_low_odd_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ph.start && !ph.sel_high && ph.divider == 8'h07) |=> !ph.done [*3] ##1 ph.done)
    else $error("low phase wrong for odd divider");

  a_high_even_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ph.start && ph.sel_high && ph.divider == 8'h02) |=> !ph.done ##1 ph.done)
    else $error("high phase wrong for even divider");

  a_low_even_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ph.start && !ph.sel_high && ph.divider == 8'h02) |=> ph.done)
    else $error("low phase wrong for even divider");

endmodule // scs_phase_timer

`default_nettype wire

// >>> scs_pkg.sv
`default_nettype none
`include "scs_regs.svh"

package scs_pkg;

  typedef logic [7:0] scs_div_t;
  typedef logic [7:0] scs_len_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD_A,
    ST_LEAD_B,
    ST_LOW,
    ST_HIGH,
    ST_TAIL_A,
    ST_TAIL_B,
    ST_SLAVE
  } scs_state_e;

  // Divider 0 cannot give a half-cycle phase; it runs as divider 1
  function automatic scs_div_t scs_eff_div(input scs_div_t dv);
    return (dv == 8'h00) ? `SCS_DIV_MIN : dv;
  endfunction

  // Low phase length in processor cycles
  function automatic scs_len_t scs_low_len(input scs_div_t dv);
    scs_div_t d;
    d = scs_eff_div(dv);
    if (d[0]) begin
      return scs_len_t'(((9'(d) + 9'h001) >> 1) * `SCS_TWO_P_CYC);
    end
    return scs_len_t'((d >> 1) * `SCS_TWO_P_CYC);
  endfunction

  // High phase length in processor cycles
  function automatic scs_len_t scs_high_len(input scs_div_t dv);
    scs_div_t d;
    d = scs_eff_div(dv);
    if (d[0]) begin
      return scs_len_t'(((9'(d) + 9'h001) >> 1) * `SCS_TWO_P_CYC);
    end
    return scs_len_t'(((d >> 1) + 8'h01) * `SCS_TWO_P_CYC);
  endfunction

endpackage

`default_nettype wire

// >>> scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// Clock-stop mode codes; bit 0 selects the early-data variant
`define SCS_MODE_LATE 2'b10
`define SCS_MODE_EARLY 2'b11
`define SCS_MODE_EARLY_BIT 0
`define SCS_MODE_STOP_BIT 1

// Slave rate clock setting: source select 1, divider 1
`define SCS_SLAVE_SRC 1'b1
`define SCS_SLAVE_DIV 8'h01
`define SCS_DIV_MIN 8'h01

// Timing: P is half a processor clock period
`define SCS_CLK_PERIOD_NS 20
`define SCS_P_NS 10
`define SCS_TWO_P_CYC ((2 * `SCS_P_NS) / `SCS_CLK_PERIOD_NS)

// Reset and idle levels
`define SCS_SCLK_IDLE 1'b1
`define SCS_SEL_IDLE 1'b1
`define SCS_SYNC_RST 4'he

// Bit positions in the pin synchroniser vector
`define SCS_SYN_SCLK 3
`define SCS_SYN_FSX 2
`define SCS_SYN_FSR 1
`define SCS_SYN_DIN 0

`endif

// >>> scs_spi_partner.sv
`timescale 1ns/1ps
`default_nettype none

module scs_spi_partner #(
  parameter int DATA_W = 8,
  parameter int HALF = 8
) (
  // Clock and role
  input wire logic ref_clk_i,
  input wire logic master_i,
  input wire logic early_i,
  // Pin view
  input wire logic sclk_i,
  input wire logic sel_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic sclk_o,
  output logic sel_o,
  output logic din_o
);
  logic [DATA_W-1:0] tx_word = '0;
  logic [DATA_W-1:0] rx_word = '0;
  logic [DATA_W-1:0] sh = '0;
  logic sampled = 1'b0;
  logic junk = 1'b0;
  logic m_sclk = 1'b1;
  logic m_sel = 1'b1;
  int oe_miss = 0;

  initial din_o = 1'b0;

  // Undriven lines wander instead of holding a level
  always @(negedge ref_clk_i) junk <= ~junk;
  assign sclk_o = master_i ? m_sclk : junk;
  assign sel_o = master_i ? m_sel : junk;

  task automatic sample_bit();
    rx_word = {rx_word[DATA_W-2:0], dout_i};
    if (dout_oe_i !== 1'b1) oe_miss++;
    sampled = 1'b1;
  endtask

  // Next bit goes out a half period before the opposite sampling edge
  task automatic launch_bit();
    if (sampled) begin
      sh = sh << 1;
      din_o = sh[DATA_W-1];
    end
  endtask

  always @(negedge sel_i) begin
    sh = tx_word;
    sampled = 1'b0;
    din_o = tx_word[DATA_W-1];
  end

  // Released data line shows the inverse of its last bit
  always @(posedge sel_i) din_o = ~din_o;

  always @(posedge sclk_i) begin
    if (sel_i === 1'b0) begin
      if (early_i) launch_bit();
      else sample_bit();
    end
  end

  always @(negedge sclk_i) begin
    if (sel_i === 1'b0) begin
      if (early_i) sample_bit();
      else launch_bit();
    end
  end

  task automatic run_frame();
    @(negedge ref_clk_i);
    m_sel = 1'b0;
    repeat (HALF) @(negedge ref_clk_i);
    for (int i = 0; i < DATA_W; i++) begin
      m_sclk = 1'b0;
      repeat (HALF) @(negedge ref_clk_i);
      m_sclk = 1'b1;
      repeat (HALF) @(negedge ref_clk_i);
    end
    m_sel = 1'b1;
    repeat (2 * HALF) @(negedge ref_clk_i);
  endtask
endmodule // scs_spi_partner

`default_nettype wire

// >>> scs_spi_port.sv
// Notes on behaviour
// - As slave the rate clock must be half the processor clock, source select 1 and divider 1.
// - As master the serial clock period is one plus the divider (divider 0 runs as 1), times two P.
// - The low phase is half the period for an odd or zero divider, else divider/2 times two P.
// - The high phase is half the period for an odd or zero divider, else divider/2+1 times two P.
// - As master with both frame polarities 1 the frame is inverted into an active-low select.
// - As slave the active-low select on both frame pins is inverted into an active frame.
// - Master means transmit clock and frame directions 1 and receive directions 0.
// - Slave means all four clock and frame directions 0, clock and select are inputs.
// - The select goes low before the first rising clock edge, where the transfer begins.
// - In mode 10b data launches on falling edges, the first after a high phase, select low T after.
// - In mode 10b a slave releases data when select rises, a master a high phase after the last rise.
// - In mode 11b data launches on rising edges, first fall one period after select falls.
// - In mode 11b the partner's data is valid around the falling edge, where it is sampled.
// - In mode 11b as master the first bit is driven a low phase after select falls.
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"

module scs_spi_port
  import scs_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Configuration
  input wire logic [1:0] clock_stop_mode_i,
  input wire logic tx_clock_polarity_i,
  input wire logic tx_frame_polarity_i,
  input wire logic rx_frame_polarity_i,
  input wire logic tx_clock_direction_i,
  input wire logic rx_clock_direction_i,
  input wire logic tx_frame_direction_i,
  input wire logic rx_frame_direction_i,
  input wire logic rate_clock_source_select_i,
  input wire logic [7:0] rate_clock_divider_i,
  // User data
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic busy_o,
  output logic config_error_o,
  // Pins
  input wire logic serial_clock_tx_pin_i,
  output logic serial_clock_tx_pin_o,
  output logic serial_clock_tx_pin_oe_o,
  input wire logic tx_frame_sync_pin_i,
  output logic tx_frame_sync_pin_o,
  output logic tx_frame_sync_pin_oe_o,
  input wire logic rx_frame_sync_pin_i,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe_o
);

  localparam int CNT_W = $clog2(DATA_W + 1);

  if (DATA_W < 2 || DATA_W > 32) begin : g_chk
    $error("DATA_W must lie between 2 and 32");
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Pin synchronisers: three stages, change taken when stages two and three agree
  logic [3:0] sync_in, s1_q, s2_q, s3_q, filt_q, filt_d;
  logic sclk_prev_q, fsx_prev_q, fsr_prev_q;

  assign sync_in = {serial_clock_tx_pin_i, tx_frame_sync_pin_i, rx_frame_sync_pin_i,
                    serial_data_in_pin_i};

  for (genvar i = 0; i < 4; i++) begin : g_filt
    assign filt_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : filt_q[i];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= `SCS_SYNC_RST;
      s2_q <= `SCS_SYNC_RST;
      s3_q <= `SCS_SYNC_RST;
      filt_q <= `SCS_SYNC_RST;
      sclk_prev_q <= `SCS_SCLK_IDLE;
      fsx_prev_q <= 1'b0;
      fsr_prev_q <= 1'b0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      sclk_prev_q <= filt_d[`SCS_SYN_SCLK];
      fsx_prev_q <= !filt_d[`SCS_SYN_FSX];
      fsr_prev_q <= !filt_d[`SCS_SYN_FSR];
    end
  end

  logic fsx_act, fsr_act, s_rise, s_fall, din;
  // Agreed value used at once; a further register would cost a sample cycle
  assign fsx_act = !filt_d[`SCS_SYN_FSX];
  assign fsr_act = !filt_d[`SCS_SYN_FSR];
  assign s_rise = filt_d[`SCS_SYN_SCLK] && !sclk_prev_q;
  assign s_fall = !filt_d[`SCS_SYN_SCLK] && sclk_prev_q;
  assign din = filt_d[`SCS_SYN_DIN];

  // Role and configuration check
  logic is_master, is_slave, slave_rate_ok, cfg_ok;
  assign is_master = tx_clock_direction_i && tx_frame_direction_i &&
                     !rx_clock_direction_i && !rx_frame_direction_i;
  assign is_slave = !tx_clock_direction_i && !tx_frame_direction_i &&
                    !rx_clock_direction_i && !rx_frame_direction_i;
  assign slave_rate_ok = (rate_clock_source_select_i == `SCS_SLAVE_SRC) &&
                         (rate_clock_divider_i == `SCS_SLAVE_DIV);
  assign cfg_ok = clock_stop_mode_i[`SCS_MODE_STOP_BIT] && tx_clock_polarity_i &&
                  tx_frame_polarity_i && rx_frame_polarity_i &&
                  (is_master || (is_slave && slave_rate_ok));

  // Phase timer
  scs_phase_if ph ();
  logic start_c, high_c;
  assign ph.start = start_c;
  assign ph.sel_high = high_c;
  assign ph.divider = rate_clock_divider_i;

  scs_phase_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ph(ph.timer)
  );

  // Transfer state
  scs_state_e state_q, state_d;
  logic sclk_q, sclk_d, sel_n_q, sel_n_d, dout_q, dout_d, doe_q, doe_d;
  logic m11_q, m11_d, smp_q, smp_d, full_q, full_d, rxv_q, rxv_d;
  logic roe_q, roe_d, ready_q, ready_d, busy_q, busy_d, err_q, err_d;
  logic [DATA_W-1:0] shift_q, shift_d, rx_q, rx_d, hold_q, hold_d, rxdat_q, rxdat_d;
  logic [CNT_W-1:0] bits_q, bits_d;
  logic load, launch, sample;

  always_comb begin
    state_d = state_q;
    sclk_d = sclk_q;
    sel_n_d = sel_n_q;
    dout_d = dout_q;
    doe_d = doe_q;
    m11_d = m11_q;
    smp_d = smp_q;
    full_d = full_q;
    shift_d = shift_q;
    rx_d = rx_q;
    hold_d = hold_q;
    rxdat_d = rxdat_q;
    bits_d = bits_q;
    rxv_d = 1'b0;
    start_c = 1'b0;
    high_c = 1'b0;
    load = 1'b0;
    launch = 1'b0;
    sample = 1'b0;
    if (tx_valid_i && !full_q) begin
      full_d = 1'b1;
      hold_d = tx_data_i;
    end
    unique case (state_q)
      ST_IDLE: begin
        sclk_d = `SCS_SCLK_IDLE;
        sel_n_d = `SCS_SEL_IDLE;
        doe_d = 1'b0;
        if (cfg_ok && is_master && full_q) begin
          state_d = ST_LEAD_A;
          sel_n_d = 1'b0;
          load = 1'b1;
          m11_d = clock_stop_mode_i[`SCS_MODE_EARLY_BIT];
          start_c = 1'b1;
          high_c = !clock_stop_mode_i[`SCS_MODE_EARLY_BIT];
        end else if (cfg_ok && is_slave) begin
          state_d = ST_SLAVE;
        end
      end
      ST_LEAD_A: if (ph.done) begin
        start_c = 1'b1;
        if (m11_q) begin
          doe_d = 1'b1;
          high_c = 1'b1;
          state_d = ST_LEAD_B;
        end else begin
          sclk_d = 1'b0;
          doe_d = 1'b1;
          state_d = ST_LOW;
        end
      end
      ST_LEAD_B: if (ph.done) begin
        sclk_d = 1'b0;
        sample = 1'b1;
        start_c = 1'b1;
        state_d = ST_LOW;
      end
      ST_LOW: if (ph.done) begin
        sclk_d = 1'b1;
        start_c = 1'b1;
        high_c = 1'b1;
        if (m11_q) begin
          if (bits_q == '0 && smp_q) begin
            doe_d = 1'b0;
            state_d = ST_TAIL_B;
          end else begin
            launch = 1'b1;
            state_d = ST_HIGH;
          end
        end else begin
          sample = 1'b1;
          state_d = (bits_q == CNT_W'(DATA_W - 1)) ? ST_TAIL_A : ST_HIGH;
        end
      end
      ST_HIGH: if (ph.done) begin
        sclk_d = 1'b0;
        start_c = 1'b1;
        state_d = ST_LOW;
        if (m11_q) begin
          sample = 1'b1;
        end else begin
          launch = 1'b1;
        end
      end
      ST_TAIL_A: if (ph.done) begin
        doe_d = 1'b0;
        start_c = 1'b1;
        state_d = ST_TAIL_B;
      end
      ST_TAIL_B: if (ph.done) begin
        sel_n_d = `SCS_SEL_IDLE;
        state_d = ST_IDLE;
      end
      ST_SLAVE: begin
        m11_d = clock_stop_mode_i[`SCS_MODE_EARLY_BIT];
        if (!(cfg_ok && is_slave)) begin
          doe_d = 1'b0;
          state_d = ST_IDLE;
        end else begin
          if (fsx_act && !fsx_prev_q) begin
            load = 1'b1;
            doe_d = 1'b1;
          end else if (!fsx_act) begin
            doe_d = 1'b0;
          end else if ((m11_q ? s_rise : s_fall) && smp_q) begin
            launch = 1'b1;
          end
          if (fsr_act && !fsr_prev_q) begin
            bits_d = '0;
          end else if (fsr_act && (m11_q ? s_fall : s_rise)) begin
            sample = 1'b1;
          end
        end
      end
    endcase
    if (launch) begin
      shift_d = {shift_q[DATA_W-2:0], 1'b0};
      dout_d = shift_q[DATA_W-2];
      smp_d = 1'b0;
    end
    if (sample) begin
      rx_d = {rx_q[DATA_W-2:0], din};
      smp_d = 1'b1;
      if (bits_q == CNT_W'(DATA_W - 1)) begin
        bits_d = '0;
        rxdat_d = {rx_q[DATA_W-2:0], din};
        rxv_d = 1'b1;
      end else begin
        bits_d = bits_q + CNT_W'(1);
      end
    end
    if (load) begin
      shift_d = hold_q;
      dout_d = hold_q[DATA_W-1];
      bits_d = '0;
      smp_d = 1'b0;
      if (full_q) begin
        full_d = 1'b0;
      end
    end
    roe_d = cfg_ok && is_master;
    ready_d = !full_d;
    busy_d = (state_d != ST_IDLE && state_d != ST_SLAVE) || (state_d == ST_SLAVE && fsx_act);
    err_d = !cfg_ok;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      sclk_q <= `SCS_SCLK_IDLE;
      sel_n_q <= `SCS_SEL_IDLE;
      dout_q <= 1'b0;
      doe_q <= 1'b0;
      m11_q <= 1'b0;
      smp_q <= 1'b0;
      full_q <= 1'b0;
      shift_q <= '0;
      rx_q <= '0;
      hold_q <= '0;
      rxdat_q <= '0;
      bits_q <= '0;
      rxv_q <= 1'b0;
      roe_q <= 1'b0;
      ready_q <= 1'b0;
      busy_q <= 1'b0;
      err_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sclk_q <= sclk_d;
      sel_n_q <= sel_n_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      m11_q <= m11_d;
      smp_q <= smp_d;
      full_q <= full_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      hold_q <= hold_d;
      rxdat_q <= rxdat_d;
      bits_q <= bits_d;
      rxv_q <= rxv_d;
      roe_q <= roe_d;
      ready_q <= ready_d;
      busy_q <= busy_d;
      err_q <= err_d;
    end
  end

  assign tx_ready_o = ready_q;
  assign rx_data_o = rxdat_q;
  assign rx_valid_o = rxv_q;
  assign busy_o = busy_q;
  assign config_error_o = err_q;
  assign serial_clock_tx_pin_o = sclk_q;
  assign serial_clock_tx_pin_oe_o = roe_q;
  assign tx_frame_sync_pin_o = sel_n_q;
  assign tx_frame_sync_pin_oe_o = roe_q;
  assign serial_data_out_pin_o = dout_q;
  assign serial_data_out_pin_oe_o = doe_q;

  sequence s_early_lead;
    (state_q == ST_LEAD_A && ph.done && m11_q) ##1 (doe_q && sclk_q);
  endsequence

  a_clk_idle_high: assert property (state_q == ST_IDLE |=> sclk_q)
    else $error("serial clock left idle level");
  a_sel_before_rise: assert property ($rose(sclk_q) && state_q != ST_SLAVE |-> !sel_n_q)
    else $error("clock rose with select high");
  a_master_drives: assert property (cfg_ok && is_master |=> roe_q)
    else $error("master not driving clock and frame");
  a_slave_inputs: assert property (is_slave |=> !roe_q)
    else $error("slave driving clock or frame");
  a_slave_release: assert property (state_q == ST_SLAVE && !fsx_act |=> !doe_q)
    else $error("slave data driven while deselected");
  a_late_first_fall: assert property (state_q == ST_LEAD_A && ph.done && !m11_q
    |=> doe_q && !sclk_q)
    else $error("first launch not on falling edge");
  a_early_first_bit: assert property (s_early_lead |-> !sel_n_q && $stable(sclk_q))
    else $error("early bit not before clock");
  a_slave_rate_cfg: assert property (is_slave && !slave_rate_ok |=> err_q)
    else $error("slave rate setting accepted");
  a_sel_active_low: assert property (state_q == ST_LEAD_A |-> !sel_n_q)
    else $error("select not driven low in frame");

endmodule // scs_spi_port

`default_nettype wire

// >>> scs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"

module testbench;
  localparam int DW = 8;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [17:0] cfg = {`SCS_MODE_LATE, 3'b111, 4'b1010, 1'b0, 8'h07};
  logic [DW-1:0] tx_data = '0;
  logic tx_valid = 1'b0;
  logic tx_ready, rx_valid, busy, config_error;
  logic [DW-1:0] rx_data;
  logic [DW-1:0] rx_last = '0;
  logic dev_sclk, sclk_oe, dev_fsx, fsx_oe, dev_dout, dout_oe;
  logic p_sclk, p_sel, p_din, sclk_w, fsx_w;
  logic p_master = 1'b0;
  logic p_early = 1'b0;
  logic psel = 1'b1;
  logic psclk = 1'b1;
  logic poe = 1'b0;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int tcyc = 0;
  int t_sf, t_ff, t_f, t_r, t_oer, t_oef, t_sr, nfall, c_e, d_e;
  int lo_bad, hi_bad, idle_bad, oe_bad, slv_bad, rx_cnt;

  always #10 ref_clk_i = ~ref_clk_i;
  assign sclk_w = sclk_oe ? dev_sclk : p_sclk;
  assign fsx_w = fsx_oe ? dev_fsx : p_sel;

  scs_spi_port #(.DATA_W(DW)) uut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .clock_stop_mode_i(cfg[17:16]), .tx_clock_polarity_i(cfg[15]),
    .tx_frame_polarity_i(cfg[14]), .rx_frame_polarity_i(cfg[13]),
    .tx_clock_direction_i(cfg[12]), .rx_clock_direction_i(cfg[11]),
    .tx_frame_direction_i(cfg[10]), .rx_frame_direction_i(cfg[9]),
    .rate_clock_source_select_i(cfg[8]), .rate_clock_divider_i(cfg[7:0]),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .busy_o(busy),
    .config_error_o(config_error),
    .serial_clock_tx_pin_i(sclk_w), .serial_clock_tx_pin_o(dev_sclk),
    .serial_clock_tx_pin_oe_o(sclk_oe), .tx_frame_sync_pin_i(fsx_w),
    .tx_frame_sync_pin_o(dev_fsx), .tx_frame_sync_pin_oe_o(fsx_oe),
    .rx_frame_sync_pin_i(p_sel), .serial_data_in_pin_i(p_din),
    .serial_data_out_pin_o(dev_dout), .serial_data_out_pin_oe_o(dout_oe)
  );

  scs_spi_partner #(.DATA_W(DW), .HALF(8)) p (
    .ref_clk_i(ref_clk_i), .master_i(p_master), .early_i(p_early),
    .sclk_i(sclk_w), .sel_i(fsx_w), .dout_i(dev_dout), .dout_oe_i(dout_oe),
    .sclk_o(p_sclk), .sel_o(p_sel), .din_o(p_din)
  );

  // Pin event monitor, in processor cycles
  always @(negedge ref_clk_i) begin
    cyc++;
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_data;
    end
    if (!p_master && config_error === 1'b0) begin
      if (psel && !dev_fsx) begin
        t_sf = cyc;
        nfall = 0;
        lo_bad = 0;
        hi_bad = 0;
      end
      if (!dev_fsx && (sclk_oe !== 1'b1 || fsx_oe !== 1'b1)) oe_bad++;
      if (dev_fsx && psel && dev_sclk !== psclk) idle_bad++;
      if (psclk && !dev_sclk) begin
        if (nfall == 0) t_ff = cyc;
        else if (cyc - t_r != d_e) hi_bad++;
        t_f = cyc;
        nfall++;
      end
      if (!psclk && dev_sclk) begin
        if (cyc - t_f != c_e) lo_bad++;
        t_r = cyc;
      end
      if (!poe && dout_oe) t_oer = cyc;
      if (poe && !dout_oe) t_oef = cyc;
      if (!psel && dev_fsx) t_sr = cyc;
    end
    if (p_master && (sclk_oe !== 1'b0 || fsx_oe !== 1'b0)) slv_bad++;
    psel = dev_fsx;
    psclk = dev_sclk;
    poe = dout_oe;
  end

  always @(posedge ref_clk_i) begin
    tcyc++;
    if (tcyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      fails++;
      $display("[FAIL] t=%0t %s", $time, msg);
    end
  endtask

  function automatic int low_len(input int d);
    int e;
    e = (d == 0) ? 1 : d;
    return (e % 2 == 1) ? (e + 1) / 2 : e / 2;
  endfunction

  function automatic int high_len(input int d);
    int e;
    e = (d == 0) ? 1 : d;
    return (e % 2 == 1) ? (e + 1) / 2 : e / 2 + 1;
  endfunction

  task automatic send_word(input logic [DW-1:0] w);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    tx_data = w;
    tx_valid = 1'b1;
    @(negedge ref_clk_i);
    tx_valid = 1'b0;
  endtask

  task automatic config_test();
    logic [18:0] tbl [8];
    tbl = '{{1'b0, 2'b10, 3'b111, 4'b1010, 1'b0, 8'h07},
            {1'b0, 2'b11, 3'b111, 4'b0000, 1'b1, 8'h01},
            {1'b1, 2'b10, 3'b111, 4'b1110, 1'b0, 8'h07},
            {1'b1, 2'b10, 3'b111, 4'b1000, 1'b0, 8'h07},
            {1'b1, 2'b01, 3'b111, 4'b1010, 1'b0, 8'h07},
            {1'b1, 2'b10, 3'b011, 4'b1010, 1'b0, 8'h07},
            {1'b1, 2'b10, 3'b111, 4'b0000, 1'b1, 8'h02},
            {1'b1, 2'b10, 3'b111, 4'b0000, 1'b0, 8'h01}};
    for (int i = 0; i < 8; i++) begin
      cfg = tbl[i][17:0];
      repeat (3) @(negedge ref_clk_i);
      check(config_error === tbl[i][18], "config error flag");
    end
    $display("test config done");
  endtask

  task automatic master_test(input logic [1:0] md, input logic [7:0] dv,
                             input logic [DW-1:0] txw, input logic [DW-1:0] pw);
    int n;
    p_master = 1'b0;
    p_early = md[`SCS_MODE_EARLY_BIT];
    p.tx_word = pw;
    cfg = {md, 3'b111, 4'b1010, 1'b0, dv};
    c_e = low_len(int'(dv));
    d_e = high_len(int'(dv));
    repeat (6) @(negedge ref_clk_i);
    p.oe_miss = 0;
    rx_cnt = 0;
    t_sf = 0;
    t_sr = 0;
    send_word(txw);
    n = 0;
    repeat (4) @(negedge ref_clk_i);
    check(busy === 1'b1, "busy during frame");
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    repeat (4) @(negedge ref_clk_i);
    check(t_sf > 0 && t_sr > t_sf && nfall == DW, "select frame");
    check(oe_bad == 0, "master pins not driven");
    check(t_r - t_ff == (DW - 1) * (c_e + d_e) + c_e, "clock period");
    check(lo_bad == 0, "low phase width");
    check(hi_bad == 0, "high phase width");
    check(idle_bad == 0, "clock moved while idle");
    check(p.rx_word === txw && p.oe_miss == 0, "master data out");
    if (md == `SCS_MODE_LATE) begin
      check(t_ff - t_sf == d_e && t_oer == t_ff, "first fall and data");
      check(t_sr - t_r == c_e + d_e, "select hold");
      check(t_oef - t_r == d_e, "data release");
    end else begin
      check(t_oer - t_sf == c_e, "first bit drive");
      check(t_ff - t_sf == c_e + d_e, "first fall");
      check(t_sr - t_r == d_e, "select hold");
    end
    if (dv >= 8'h07) begin
      check(rx_cnt == 1 && rx_last === pw, "master data in");
    end
    $display("test master mode %b div %0d done", md, dv);
  endtask

  task automatic slave_test(input logic [1:0] md, input logic [DW-1:0] txw,
                            input logic [DW-1:0] pw);
    p_master = 1'b1;
    p_early = md[`SCS_MODE_EARLY_BIT];
    p.tx_word = pw;
    cfg = {md, 3'b111, 4'b0000, `SCS_SLAVE_SRC, `SCS_SLAVE_DIV};
    repeat (6) @(negedge ref_clk_i);
    check(config_error === 1'b0, "slave config accepted");
    send_word(txw);
    p.oe_miss = 0;
    rx_cnt = 0;
    slv_bad = 0;
    p.run_frame();
    check(slv_bad == 0, "slave drove clock or select");
    check(p.rx_word === txw && p.oe_miss == 0, "slave data out");
    check(rx_cnt == 1 && rx_last === pw, "slave data in");
    check(dout_oe === 1'b0, "slave data release");
    $display("test slave mode %b done", md);
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge ref_clk_i);
    check(dev_sclk === `SCS_SCLK_IDLE && dev_fsx === `SCS_SEL_IDLE, "reset levels");
    nrst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    check(tx_ready === 1'b1 && config_error === 1'b0, "ready after reset");
    $display("test reset done");
    config_test();
    master_test(`SCS_MODE_LATE, 8'h07, 8'ha5, 8'h3c);
    master_test(`SCS_MODE_EARLY, 8'h08, 8'h96, 8'hc3);
    master_test(`SCS_MODE_LATE, 8'h02, 8'h81, 8'h00);
    master_test(`SCS_MODE_EARLY, 8'h00, 8'h7e, 8'h00);
    slave_test(`SCS_MODE_LATE, 8'h5a, 8'he1);
    slave_test(`SCS_MODE_EARLY, 8'h1f, 8'hb4);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
